/* File: design/ext_data_mem_interface.sv */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "xmem_defs.svh"
module ext_data_mem_interface (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic [7:0]  p0_i,
  output logic      [7:0]  p0_o,
  output logic             p0_oe,
  output logic      [7:0]  p2_o,
  output logic             p2_oe,
  output logic             ale_o,
  output logic             ale_oe,
  output logic             rd_n_o,
  output logic             wr_n_o,
  input  wire logic        cpu_idle,
  input  wire logic        wdt_reset_evt,
  output logic             reset_pin_o,
  output logic             reset_pin_oe,
  output logic             watchdog_count_en
);
  import xmem_pkg::*;

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  ctl_t       c_r;
  ctl_t       c_nxt;
  logic [7:0] p0_sync;
  logic       ale_idle_pulse;
  logic       fast;
  logic       ws_hi_eff;
  logic       wd_idle_eff;
  logic       rst_off_eff;
  logic       take;
  logic       start;
  logic       internal;
  logic [3:0] setup_n;
  logic [3:0] width_n;

  pin_sync u_p0_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (p0_i),
    .dout    (p0_sync)
  );

  ale_idle_gen u_ale_gen (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .fast_mode (c_r.mode[`MODE_FAST_BIT]),
    .pulse     (ale_idle_pulse)
  );

  function automatic logic [31:0] read_reg(input ctl_t s,
                                           input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `AUX_ADDR:   d[4:0]  = s.aux;
      `MODE_ADDR:  d[1:0]  = s.mode;
      `WDCTL_ADDR: d[1:0]  = s.wdctl;
      `PORT_ADDR:  d[17:0] = {s.p2_idle_drv, s.p0_idle_drv,
                              s.p2_lat, s.p0_lat};
      `CMD_ADDR:   d       = {s.addr, s.wdata, 6'b00_0000,
                              s.linear, s.dir_wr};
      `STAT_ADDR:  d[15:0] = {s.rdata, 6'b00_0000, s.int_hit,
                              (s.st != ST_IDLE)};
      default:     d       = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_reg

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    c_nxt       = c_r;
    fast        = c_r.mode[`MODE_FAST_BIT];
    ws_hi_eff   = fast & c_r.aux[`AUX_WS_HI_BIT];
    wd_idle_eff = fast ? c_r.wdctl[`WDCTL_WATCHDOG_IDLE_STOP_BIT]
                       : c_r.aux[`AUX_WATCHDOG_IDLE_STOP_BIT];
    rst_off_eff = fast ? c_r.wdctl[`WDCTL_RSTOFF_BIT]
                       : c_r.aux[`AUX_RSTOFF_BIT];
    take        = hsel & htrans[1] & hready;
    start       = 1'b0;
    internal    = 1'b0;
    setup_n     = `COMPAT_SETUP;
    width_n     = c_r.acc_ws[0] ? `COMPAT_STROBE_1
                                : `COMPAT_STROBE_0;
    if (c_r.acc_fast) begin
      unique case (c_r.acc_ws)
        2'd0: begin
          setup_n = `FAST_SETUP_0;
          width_n = `FAST_STROBE_0;
        end
        2'd1: begin
          setup_n = `FAST_SETUP_1;
          width_n = `FAST_STROBE_1;
        end
        2'd2: begin
          setup_n = `FAST_SETUP_2;
          width_n = `FAST_STROBE_2;
        end
        2'd3: begin
          setup_n = `FAST_SETUP_3;
          width_n = `FAST_STROBE_3;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Bus slave: reads wait one cycle, writes take no wait
    // --------------------------------------------------------------
    c_nxt.ap_valid = 1'b0;
    c_nxt.hresp    = 1'b0;
    if (c_r.ap_valid) begin
      if (c_r.ap_write) begin
        unique case (c_r.ap_addr)
          `AUX_ADDR:   c_nxt.aux   = hwdata[4:0];
          `MODE_ADDR:  c_nxt.mode  = hwdata[1:0];
          `WDCTL_ADDR: c_nxt.wdctl = hwdata[1:0];
          `PORT_ADDR: begin
            c_nxt.p0_lat      = hwdata[7:0];
            c_nxt.p2_lat      = hwdata[15:8];
            c_nxt.p0_idle_drv = hwdata[`PORT_P0_IDLE_BIT];
            c_nxt.p2_idle_drv = hwdata[`PORT_P2_IDLE_BIT];
          end
          `CMD_ADDR:   start = (c_r.st == ST_IDLE);
          default: ;
        endcase
      end else begin
        c_nxt.hrdata    = read_reg(c_r, c_r.ap_addr);
        c_nxt.hreadyout = 1'b1;
      end
    end
    if (take) begin
      c_nxt.ap_valid  = 1'b1;
      c_nxt.ap_write  = hwrite;
      c_nxt.ap_addr   = haddr[11:0];
      c_nxt.hreadyout = hwrite;
    end

    // --------------------------------------------------------------
    // Access sequencer
    // --------------------------------------------------------------
    unique case (c_r.st)
      ST_IDLE: begin
        if (start) begin
          c_nxt.dir_wr   = hwdata[`CMD_WRITE_BIT];
          c_nxt.linear   = hwdata[`CMD_LINEAR_BIT];
          c_nxt.wdata    = hwdata[15:8];
          c_nxt.addr     = hwdata[`CMD_LINEAR_BIT] ? hwdata[31:16]
                                                   : {8'h00, hwdata[23:16]};
          c_nxt.acc_fast = fast;
          c_nxt.acc_ws   = {ws_hi_eff, c_r.aux[`AUX_WS_LO_BIT]};
          internal       = !c_r.aux[`AUX_EXT_ALL_BIT] &&
                           (c_nxt.addr <= `INT_MEM_TOP);
          c_nxt.int_hit  = internal;
          if (!internal) begin
            c_nxt.st = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        c_nxt.st  = ST_SETUP;
        c_nxt.cnt = setup_n - 4'd1;
      end
      ST_SETUP: begin
        if (c_r.cnt == 4'd0) begin
          c_nxt.st  = ST_STROBE;
          c_nxt.cnt = width_n - 4'd1;
        end else begin
          c_nxt.cnt = c_r.cnt - 4'd1;
        end
      end
      ST_STROBE: begin
        if (c_r.cnt == 4'd0) begin
          c_nxt.st  = ST_DONE;
          c_nxt.cnt = c_r.dir_wr ? 4'd0 : `READ_SYNC_LAG;
        end else begin
          c_nxt.cnt = c_r.cnt - 4'd1;
        end
      end
      ST_DONE: begin
        if (c_r.cnt == 4'd0) begin
          c_nxt.st = ST_IDLE;
        end else begin
          c_nxt.cnt = c_r.cnt - 4'd1;
        end
      end
      default: c_nxt.st = ST_IDLE;
    endcase

    // --------------------------------------------------------------
    // Read capture
    // --------------------------------------------------------------
    // Pin value at the strobe's last edge leaves the synchroniser
    // in the final done cycle; busy stays up until it is stored
    if (c_r.st == ST_DONE && c_r.cnt == 4'd0 && !c_r.dir_wr) begin
      c_nxt.rdata = p0_sync;
    end

    // --------------------------------------------------------------
    // Pin drive from the next state
    // --------------------------------------------------------------
    c_nxt.rd_n  = 1'b1;
    c_nxt.wr_n  = 1'b1;
    c_nxt.ale   = 1'b0;
    c_nxt.ale_oe = 1'b1;
    c_nxt.p0_o  = c_nxt.addr[7:0];
    c_nxt.p0_oe = 1'b1;
    c_nxt.p2_o  = c_nxt.linear ? c_nxt.addr[15:8]
                               : c_nxt.p2_lat;
    c_nxt.p2_oe = 1'b1;
    unique case (c_nxt.st)
      ST_IDLE: begin
        c_nxt.ale    = c_nxt.aux[`AUX_IDLE_OFF_BIT] | ale_idle_pulse;
        c_nxt.ale_oe = !c_nxt.aux[`AUX_IDLE_OFF_BIT];
        c_nxt.p0_o   = c_nxt.p0_lat;
        c_nxt.p0_oe  = c_nxt.p0_idle_drv;
        c_nxt.p2_o   = c_nxt.p2_lat;
        c_nxt.p2_oe  = c_nxt.p2_idle_drv;
      end
      ST_ADDR: c_nxt.ale = 1'b1;
      ST_SETUP: ;
      ST_STROBE: begin
        if (c_nxt.dir_wr) begin
          c_nxt.wr_n = 1'b0;
          c_nxt.p0_o = c_nxt.wdata;
        end else begin
          c_nxt.rd_n  = 1'b0;
          c_nxt.p0_oe = 1'b0;
        end
      end
      ST_DONE: begin
        c_nxt.p0_o  = c_nxt.wdata;
        c_nxt.p0_oe = c_nxt.dir_wr;
      end
      default: ;
    endcase

    // --------------------------------------------------------------
    // Watchdog controls
    // --------------------------------------------------------------
    c_nxt.wd_count_en = !(cpu_idle && wd_idle_eff);
    if (wdt_reset_evt && !rst_off_eff) begin
      c_nxt.rst_cnt = `RST_OUT_CYCLES;
    end else if (c_r.rst_cnt != 8'd0) begin
      c_nxt.rst_cnt = c_r.rst_cnt - 8'd1;
    end
    c_nxt.rst_oe = (c_nxt.rst_cnt != 8'd0);
    c_nxt.rst_o  = c_r.mode[`MODE_POL_BIT];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      c_r             <= '0;
      c_r.st          <= ST_IDLE;
      c_r.aux         <= `AUX_RESET;
      c_r.mode        <= `MODE_RESET;
      c_r.wdctl       <= `WDCTL_RESET;
      c_r.p0_lat      <= `PORT_LAT_RESET;
      c_r.p2_lat      <= `PORT_LAT_RESET;
      c_r.hreadyout   <= 1'b1;
      c_r.rd_n        <= 1'b1;
      c_r.wr_n        <= 1'b1;
      c_r.ale_oe      <= 1'b1;
      c_r.wd_count_en <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout         = c_r.hreadyout;
  assign hrdata            = c_r.hrdata;
  assign hresp             = c_r.hresp;
  assign p0_o              = c_r.p0_o;
  assign p0_oe             = c_r.p0_oe;
  assign p2_o              = c_r.p2_o;
  assign p2_oe             = c_r.p2_oe;
  assign ale_o             = c_r.ale;
  assign ale_oe            = c_r.ale_oe;
  assign rd_n_o            = c_r.rd_n;
  assign wr_n_o            = c_r.wr_n;
  assign reset_pin_o       = c_r.rst_o;
  assign reset_pin_oe      = c_r.rst_oe;
  assign watchdog_count_en = c_r.wd_count_en;
endmodule : ext_data_mem_interface

/* File: common/xmem_defs.svh */
`ifndef XMEM_DEFS_SVH
`define XMEM_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses (decoded on haddr[11:0])
// ----------------------------------------------------------------
`define AUX_IDX            12'h08E
`define AUX_ADDR           12'h238
`define MODE_ADDR          12'h000
`define WDCTL_ADDR         12'h004
`define PORT_ADDR          12'h008
`define CMD_ADDR           12'h00C
`define STAT_ADDR          12'h010

// ----------------------------------------------------------------
// Auxiliary control fields and reset
// ----------------------------------------------------------------
`define AUX_RESET          5'h00
`define AUX_IDLE_OFF_BIT   0
`define AUX_EXT_ALL_BIT    1
`define AUX_WS_LO_BIT      2
`define AUX_WS_HI_BIT      3
`define AUX_RSTOFF_BIT     3
`define AUX_WATCHDOG_IDLE_STOP_BIT     4

// ----------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------
`define MODE_FAST_BIT      0
`define MODE_POL_BIT       1
`define MODE_RESET         2'h0
`define WDCTL_WATCHDOG_IDLE_STOP_BIT   0
`define WDCTL_RSTOFF_BIT   1
`define WDCTL_RESET        2'h0
`define PORT_P0_IDLE_BIT   16
`define PORT_P2_IDLE_BIT   17
`define PORT_LAT_RESET     8'hFF
`define CMD_WRITE_BIT      0
`define CMD_LINEAR_BIT     1
`define STAT_BUSY_BIT      0
`define STAT_INT_BIT       1

// ----------------------------------------------------------------
// Timing counts in system clock cycles, and the top internal memory address
// ----------------------------------------------------------------
`define FAST_SETUP_0       4'd1
`define FAST_SETUP_1       4'd1
`define FAST_SETUP_2       4'd2
`define FAST_SETUP_3       4'd2
`define FAST_STROBE_0      4'd1
`define FAST_STROBE_1      4'd2
`define FAST_STROBE_2      4'd2
`define FAST_STROBE_3      4'd3
`define COMPAT_SETUP       4'd2
`define COMPAT_STROBE_0    4'd3
`define COMPAT_STROBE_1    4'd15
`define READ_SYNC_LAG      4'd1
`define ALE_DIV_FAST       2'd2
`define ALE_DIV_COMPAT     2'd3
`define RST_OUT_CYCLES     8'd16
`define INT_MEM_TOP        16'h00FF

`endif

/* File: common/xmem_pkg.sv */
package xmem_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_SETUP  = 3'b011,
    ST_STROBE = 3'b010,
    ST_DONE   = 3'b110
  } xstate_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } sync_t;

  typedef struct packed {
    logic [1:0] cnt;
    logic       pulse;
  } ale_gen_t;

  typedef struct packed {
    xstate_t     st;
    logic [3:0]  cnt;
    logic [4:0]  aux;
    logic [1:0]  mode;
    logic [1:0]  wdctl;
    logic [7:0]  p0_lat;
    logic [7:0]  p2_lat;
    logic        p0_idle_drv;
    logic        p2_idle_drv;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        dir_wr;
    logic        linear;
    logic        acc_fast;
    logic [1:0]  acc_ws;
    logic [7:0]  rdata;
    logic        int_hit;
    logic        ap_valid;
    logic        ap_write;
    logic [11:0] ap_addr;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        ale;
    logic        ale_oe;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  p0_o;
    logic        p0_oe;
    logic [7:0]  p2_o;
    logic        p2_oe;
    logic        rst_o;
    logic        rst_oe;
    logic [7:0]  rst_cnt;
    logic        wd_count_en;
  } ctl_t;

endpackage : xmem_pkg

/* File: design/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  import xmem_pkg::*;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.s2;
endmodule : pin_sync

/* File: design/ale_idle_gen.sv */
`timescale 1ns/1ps
`include "xmem_defs.svh"
module ale_idle_gen (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic fast_mode,
  output logic      pulse
);
  import xmem_pkg::*;

  ale_gen_t g_r;
  ale_gen_t g_nxt;
  logic [1:0] div;

  // One high cycle out of every div cycles
  always_comb begin
    g_nxt = g_r;
    div   = fast_mode ? `ALE_DIV_FAST : `ALE_DIV_COMPAT;
    if (g_r.cnt >= div - 2'd1) begin
      g_nxt.cnt = 2'd0;
    end else begin
      g_nxt.cnt = g_r.cnt + 2'd1;
    end
    g_nxt.pulse = (g_nxt.cnt == 2'd0);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      g_r <= '0;
    end else begin
      g_r <= g_nxt;
    end
  end

  assign pulse = g_r.pulse;
endmodule : ale_idle_gen

/* File: bench/ext_data_mem_interface_props.sv */
`timescale 1ns/1ps
module xmem_props (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] p0_o,
  input wire logic       p0_oe,
  input wire logic [7:0] p2_o,
  input wire logic       p2_oe,
  input wire logic       ale_o,
  input wire logic       rd_n_o,
  input wire logic       wr_n_o,
  input wire logic       cpu_idle,
  input wire logic       watchdog_count_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_on;
    $fell(wr_n_o);
  endsequence
  sequence s_rd_on;
    $fell(rd_n_o);
  endsequence

  chk_one_strobe: assert property (rd_n_o || wr_n_o)
    else $error("both strobes low");
  chk_strobe_after: assert property (s_wr_on or s_rd_on |-> !ale_o)
    else $error("strobe before latch fall");
  chk_rd_float: assert property (!rd_n_o |-> !p0_oe)
    else $error("low port driven in read");
  chk_wr_drive: assert property (!wr_n_o |-> p0_oe && p2_oe)
    else $error("ports not driven in write");
  chk_wr_hold: assert property (
    !wr_n_o && !$past(wr_n_o) |-> $stable(p0_o))
    else $error("write data moved");
  chk_hi_hold: assert property (
    !rd_n_o && !$past(rd_n_o) |-> p2_oe && $stable(p2_o))
    else $error("high byte moved");
  chk_addr_fall: assert property ($fell(ale_o) && p0_oe && p2_oe |->
    $stable(p0_o) && $stable(p2_o))
    else $error("address moved at latch fall");
  chk_wr_width: assert property (s_wr_on |-> ##[1:15] wr_n_o)
    else $error("write strobe too long");
  chk_wd_run: assert property (!cpu_idle |=> watchdog_count_en)
    else $error("watchdog stopped while busy");
endmodule : xmem_props

bind ext_data_mem_interface xmem_props u_xmem_props (.sys_clk, .rst_n,
  .p0_o, .p0_oe, .p2_o, .p2_oe, .ale_o, .rd_n_o, .wr_n_o, .cpu_idle,
  .watchdog_count_en);

/* File: bench/xram_model.sv */
`timescale 1ns/1ps
module xram_model (
  input  wire logic       ale,
  input  wire logic [7:0] ad,
  input  wire logic [7:0] a_hi,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       slow,
  output logic      [7:0] dq
);
  logic [7:0] lat;
  logic [7:0] last = 8'h00;
  logic       ok = 1'b0;
  logic [7:0] mem [0:65535];

  // Address latch, transparent while ale high
  always_latch if (ale) lat <= ad;
  always @(posedge wr_n) mem[{a_hi, lat}] <= ad;
  always @(negedge rd_n) begin
    ok = 1'b0;
    #(slow ? 12 : 2);
    ok = !rd_n;
  end
  always @(posedge rd_n) begin
    last = mem[{a_hi, lat}];
    ok = 1'b0;
  end
  // Released bus shows inverse of last data
  assign dq = ok ? mem[{a_hi, lat}] : ~last;
endmodule : xram_model

/* File: bench/tb_ext_data_mem_interface.sv */
`timescale 1ns/1ps
`include "xmem_defs.svh"
module tb_ext_data_mem_interface;
  logic sys_clk, rst_n, hsel, hwrite, hready, cpu_idle, wdt_reset_evt;
  logic hreadyout, hresp, p0_oe, p2_oe, ale_o, ale_oe, rd_n_o, wr_n_o;
  logic reset_pin_o, reset_pin_oe, watchdog_count_en, slow, pa, ps;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [1:0]  htrans;
  logic [7:0]  p0_o, p2_o, p0_i, dq;
  int errors, compares, sc, wc, last_s, last_w, nstb;
  wire ale_pin = ale_oe ? ale_o : 1'b1;
  assign p0_i = p0_oe ? p0_o : dq;
  assign hready = hreadyout;

  ext_data_mem_interface u_ext_data_mem_interface (.sys_clk, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready, .hreadyout,
    .hrdata, .hresp, .p0_i, .p0_o, .p0_oe, .p2_o, .p2_oe, .ale_o, .ale_oe,
    .rd_n_o, .wr_n_o, .cpu_idle, .wdt_reset_evt, .reset_pin_o,
    .reset_pin_oe, .watchdog_count_en);
  xram_model u_xram_model (.ale(ale_pin), .ad(p0_i), .a_hi(p2_o),
    .rd_n(rd_n_o), .wr_n(wr_n_o), .slow, .dq);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Strobe timing monitor
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    sc = (pa && !ale_pin) ? 0 : sc + 1;
    if (ps && !(wr_n_o && rd_n_o)) begin
      last_s = sc;
      nstb++;
    end
    if (!(wr_n_o && rd_n_o)) wc++;
    else begin
      if (!ps) last_w = wc;
      wc = 0;
    end
    pa = ale_pin;
    ps = wr_n_o && rd_n_o;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task give_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task tick_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      if (++n > 40) begin
        errors++;
        give_verdict;
      end
      @(posedge sys_clk);
    end
  endtask : tick_rdy

  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    tick_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    tick_rdy;
    st = hrdata;
  endtask : ahb

  task acc(input logic [31:0] cmd);
    int n;
    ahb(1'b1, `CMD_ADDR, cmd);
    n = 0;
    do begin
      ahb(1'b0, `STAT_ADDR, 32'h0000_0000);
      if (++n > 40) begin
        errors++;
        give_verdict;
      end
    end while (st[0] !== 1'b0);
  endtask : acc

  task cnt_ale(input logic [31:0] exp);
    int c;
    c = 0;
    repeat (3) @(posedge sys_clk);
    repeat (12) begin
      @(posedge sys_clk);
      c += ale_pin;
    end
    check(32'(c), exp);
  endtask : cnt_ale

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    ahb(1'b0, `AUX_ADDR, 32'h0000_0000);
    check(st, 32'h0000_0000);
    ahb(1'b1, 12'h300, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h300, 32'h0000_0000);
    check(st, 32'h0000_0000);
    $display("t_regs done");
  endtask : t_regs

  task t_fast;
    int fw[4] = '{1, 2, 2, 3};
    int fs[4] = '{1, 1, 2, 2};
    logic [15:0] a;
    ahb(1'b1, `MODE_ADDR, 32'h0000_0001);
    for (int ws = 0; ws < 4; ws++) begin
      a = 16'h1200 + 16'(ws);
      ahb(1'b1, `AUX_ADDR, {28'h000_0000, 2'(ws), 2'b10});
      acc({a, 8'hA0 + 8'(ws), 8'h03});
      check(32'(last_w), 32'(fw[ws]));
      check(32'(last_s), 32'(fs[ws]));
      check(u_xram_model.mem[a], 8'hA0 + 8'(ws));
      acc({a, 8'h00, 8'h02});
      check(st[15:8], 8'hA0 + 8'(ws));
    end
    $display("t_fast done");
  endtask : t_fast

  task t_compat;
    ahb(1'b1, `MODE_ADDR, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      ahb(1'b1, `AUX_ADDR, k ? 32'h0000_000E : 32'h0000_0002);
      acc({16'h8000 + 16'(k), 8'h5C, 8'h03});
      check(32'(last_w), k ? 32'd15 : 32'd3);
      check(32'(last_s), 32'd2);
      acc({16'h8000 + 16'(k), 8'h00, 8'h02});
      check(st[15:8], 8'h5C);
    end
    slow <= 1'b0;
    $display("t_compat done");
  endtask : t_compat

  task t_map;
    int n0;
    ahb(1'b1, `AUX_ADDR, 32'h0000_0000);
    n0 = nstb;
    acc({16'h0040, 8'h11, 8'h03});
    check(st[1], 1'b1);
    check(32'(nstb), 32'(n0));
    acc({16'h0100, 8'h77, 8'h03});
    check(u_xram_model.mem[16'h0100], 8'h77);
    ahb(1'b1, `AUX_ADDR, 32'h0000_0002);
    ahb(1'b1, `PORT_ADDR, 32'h0000_5AFF);
    acc({16'h7733, 8'h3C, 8'h01});
    check(u_xram_model.mem[16'h5A33], 8'h3C);
    $display("t_map done");
  endtask : t_map

  task t_ale;
    ahb(1'b1, `MODE_ADDR, 32'h0000_0001);
    ahb(1'b1, `AUX_ADDR, 32'h0000_0000);
    cnt_ale(32'd6);
    ahb(1'b1, `MODE_ADDR, 32'h0000_0000);
    cnt_ale(32'd4);
    ahb(1'b1, `AUX_ADDR, 32'h0000_0001);
    cnt_ale(32'd12);
    $display("t_ale done");
  endtask : t_ale

  task t_wdog;
    ahb(1'b1, `AUX_ADDR, 32'h0000_0010);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(watchdog_count_en, 1'b0);
    ahb(1'b1, `MODE_ADDR, 32'h0000_0003);
    repeat (3) @(posedge sys_clk);
    check(watchdog_count_en, 1'b1);
    ahb(1'b1, `WDCTL_ADDR, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    check(watchdog_count_en, 1'b0);
    cpu_idle <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, `WDCTL_ADDR, k ? 32'h0000_0002 : 32'h0000_0000);
      wdt_reset_evt <= 1'b1;
      @(posedge sys_clk);
      wdt_reset_evt <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check({reset_pin_oe, reset_pin_o}, k ? 2'b01 : 2'b11);
      repeat (20) @(posedge sys_clk);
    end
    $display("t_wdog done");
  endtask : t_wdog

  initial begin
    errors = 0;
    compares = 0;
    sc = 0;
    wc = 0;
    nstb = 0;
    pa = 1'b1;
    ps = 1'b1;
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    cpu_idle = 1'b0;
    wdt_reset_evt = 1'b0;
    slow = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_fast;
    t_compat;
    t_map;
    t_ale;
    t_wdog;
    give_verdict;
  end
endmodule : tb_ext_data_mem_interface
